// File: design/mci_pkg.sv
// Shared constants and types of the meter command interpreter
package mci_pkg;
  // Register byte offsets
  localparam logic [7:0] MCI_OFS_CTRL = 8'h00;
  localparam logic [7:0] MCI_OFS_STATUS = 8'h04;
  localparam logic [7:0] MCI_OFS_SETTINGS = 8'h08;
  localparam logic [7:0] MCI_OFS_MEAS = 8'h0C;
  localparam logic [7:0] MCI_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] MCI_OFS_IRQ_MASK = 8'h14;
  // Field positions
  localparam int MCI_CTRL_COMPAT_BIT = 0;
  localparam int MCI_CTRL_CONT_BIT = 1;
  localparam int MCI_STAT_RUN_BIT = 0;
  localparam int MCI_OP_EOC_BIT = 8;
  localparam int MCI_QUES_ERR_BIT = 9;
  localparam int MCI_SET_COMP_BIT = 4;
  localparam int MCI_SET_CONTR_LSB = 8;
  localparam int MCI_IRQ_NAK_BIT = 0;
  localparam int MCI_IRQ_NEW_BIT = 1;
  localparam int MCI_IRQ_ERR_BIT = 2;
  // Access levels and contrast in tenths
  localparam logic [2:0] MCI_LVL_START = 3'h1;
  localparam logic [2:0] MCI_LVL_RANGE = 3'h2;
  localparam logic [2:0] MCI_LVL_LIMIT = 3'h3;
  localparam logic [2:0] MCI_LVL_FULL = 3'h4;
  localparam logic [3:0] MCI_CONTR_MAX = 4'hA;
  // Values after reset
  localparam logic [2:0] MCI_RST_LEVEL = 3'h4;
  localparam logic [3:0] MCI_RST_CONTR = 4'h5;
  localparam logic MCI_RST_COMPAT = 1'b0;
  localparam logic MCI_RST_CONT = 1'b1;
  localparam logic [15:0] MCI_IDN_TAG = 16'hD1D0; // Arbitrary value

  typedef enum logic [4:0] {
    MCI_OP_IDN = 5'h00,
    MCI_OP_INIT = 5'h01,
    MCI_OP_ABORT = 5'h02,
    MCI_OP_FETCH = 5'h03,
    MCI_OP_RANGE = 5'h04,
    MCI_OP_LIMIT = 5'h05,
    MCI_OP_ACCESS = 5'h06,
    MCI_OP_CONTRAST = 5'h07,
    MCI_OP_COMP_EN = 5'h08,
    MCI_OP_OTHER = 5'h09,
    MCI_OP_DRY = 5'h0A,
    MCI_OP_LEG_A = 5'h10,
    MCI_OP_LEG_READ = 5'h11,
    MCI_OP_ADDR_GRP = 5'h12,
    MCI_OP_ADDR_USR = 5'h13,
    MCI_OP_CONTACT_V = 5'h14,
    MCI_OP_RANGE_SAVE = 5'h15,
    MCI_OP_DISP_TEST = 5'h16,
    MCI_OP_KEY_LOCK = 5'h17
  } mci_op_e;

  typedef enum logic [1:0] {
    MCI_ST_IDLE = 2'b01,
    MCI_ST_RUN = 2'b10
  } mci_run_e;

  typedef struct packed {
    mci_op_e op;
    logic query;
    logic has_param;
    logic short_form;
    logic [15:0] param;
  } mci_cmd_s;

  typedef struct packed {
    logic valid;
    logic ack;
    logic nak;
    logic [31:0] data;
  } mci_rsp_s;

  typedef struct packed {
    mci_run_e run;
    logic compat;
    logic cont;
    logic [2:0] level;
    logic [3:0] contrast;
    logic comp_en;
    logic eoc;
    logic qerr;
    logic [31:0] meas_buf;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic irq;
    logic wb_ack;
    logic [31:0] wb_dat;
    mci_rsp_s rsp;
  } mci_state_s;
endpackage

// File: design/mci_core.sv
// Meter command interpreter: decoded commands in, ACK/NAK answers out
// Operation
// - Legacy commands are recognized only while compatibility mode is on.
// - Group or user address setting commands always answer NAK.
// - Legacy combined legacy_command_a and legacy read commands answer NAK.
// - Dry-contact function and its voltage limit command answer NAK.
// - Identification query returns a new string holding the device identifier.
// - Continuous mode writes the newest value into the output buffer.
// - Continuous mode sets operation status bit 8 on a valid value.
// - Continuous mode sets questionable status bit 9 while an error exists.
// - Access level gates functions: 1 start/stop, 2 range, 3 limits, 4 all.
// - Contrast takes 0.0 to 1.0, minimum to maximum.
// - Contrast query returns the setting with one decimal digit.
// - Comparator enable command: 1 or ON enables, 0 or OFF disables.
// - Comparator enable query answers 1 when enabled, 0 when disabled.
// - Range save, segment test and keypad lock answer ACK, no effect.
// - Long and short spellings of a command behave identically.
// - Query with parameters sets first, then returns the resulting value.
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module mci_core #(
  parameter int AW = 8,
  parameter logic [15:0] DEV_ID = 16'h0001 // Arbitrary identifier value
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Decoded command in, answer out
  input wire logic cmd_valid_i,
  input wire mci_pkg::mci_cmd_s cmd_i,
  output mci_pkg::mci_rsp_s rsp_o,
  // Measurement source
  input wire logic meas_valid_i,
  input wire logic [31:0] meas_value_i,
  input wire logic meas_error_i,
  // Interrupt
  output logic irq_o
);
  if (AW < 5 || AW > 8) begin : g_aw_check
    $error("AW must lie between 5 and 8");
  end

  mci_pkg::mci_state_s s_reg;
  mci_pkg::mci_state_s s_next;
  logic [7:0] adr;
  logic wb_hit;
  logic wb_wr;
  logic ok;
  logic legacy;
  logic [2:0] need;
  logic [31:0] dat;
  logic [2:0] ev;
  logic capture;

  assign adr = 8'(wb_adr_i) & 8'hFC;
  assign wb_hit = wb_cyc_i & wb_stb_i & ~s_reg.wb_ack;
  assign wb_wr = wb_hit & wb_we_i;
  assign legacy = cmd_i.op >= mci_pkg::MCI_OP_LEG_A;
  assign capture = (s_reg.run == mci_pkg::MCI_ST_RUN) & s_reg.cont & meas_valid_i;

  // Least access level each command needs
  always_comb begin
    unique case (cmd_i.op)
      mci_pkg::MCI_OP_RANGE: need = mci_pkg::MCI_LVL_RANGE;
      mci_pkg::MCI_OP_LIMIT: need = mci_pkg::MCI_LVL_LIMIT;
      mci_pkg::MCI_OP_CONTRAST, mci_pkg::MCI_OP_COMP_EN, mci_pkg::MCI_OP_OTHER:
        need = mci_pkg::MCI_LVL_FULL;
      default: need = mci_pkg::MCI_LVL_START;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    ok = 1'b1;
    dat = 32'h0000_0000;
    ev = 3'h0;
    s_next.rsp = '0;
    s_next.wb_ack = wb_hit;
    s_next.wb_dat = 32'h0000_0000;

    // Short and long spellings arrive as the same opcode; short_form is ignored
    if (cmd_valid_i) begin
      unique case (cmd_i.op)
        mci_pkg::MCI_OP_IDN: dat = {mci_pkg::MCI_IDN_TAG, DEV_ID};
        mci_pkg::MCI_OP_INIT: s_next.run = mci_pkg::MCI_ST_RUN;
        mci_pkg::MCI_OP_ABORT: s_next.run = mci_pkg::MCI_ST_IDLE;
        mci_pkg::MCI_OP_FETCH: begin
          dat = s_reg.meas_buf;
          s_next.eoc = 1'b0;
        end
        mci_pkg::MCI_OP_RANGE, mci_pkg::MCI_OP_LIMIT, mci_pkg::MCI_OP_OTHER: ok = 1'b1;
        mci_pkg::MCI_OP_ACCESS: begin
          if (cmd_i.has_param) begin
            if (cmd_i.param >= 16'(mci_pkg::MCI_LVL_START) &&
                cmd_i.param <= 16'(mci_pkg::MCI_LVL_FULL)) begin
              s_next.level = cmd_i.param[2:0];
            end else begin
              ok = 1'b0;
            end
          end
          dat = 32'(s_next.level);
        end
        mci_pkg::MCI_OP_CONTRAST: begin
          if (cmd_i.has_param) begin
            if (cmd_i.param <= 16'(mci_pkg::MCI_CONTR_MAX)) begin
              s_next.contrast = cmd_i.param[3:0];
            end else begin
              ok = 1'b0;
            end
          end
          // Tenths give exactly one decimal digit
          dat = 32'(s_next.contrast);
        end
        mci_pkg::MCI_OP_COMP_EN: begin
          if (cmd_i.has_param) begin
            if (cmd_i.param <= 16'h0001) begin
              s_next.comp_en = cmd_i.param[0];
            end else begin
              ok = 1'b0;
            end
          end
          dat = 32'(s_next.comp_en);
        end
        mci_pkg::MCI_OP_DRY, mci_pkg::MCI_OP_CONTACT_V: ok = 1'b0;
        mci_pkg::MCI_OP_LEG_A, mci_pkg::MCI_OP_LEG_READ: ok = 1'b0;
        mci_pkg::MCI_OP_ADDR_GRP, mci_pkg::MCI_OP_ADDR_USR: ok = 1'b0;
        mci_pkg::MCI_OP_RANGE_SAVE, mci_pkg::MCI_OP_DISP_TEST,
        mci_pkg::MCI_OP_KEY_LOCK: ok = 1'b1;
        default: ok = 1'b0;
      endcase
      if (s_reg.level < need) begin
        ok = 1'b0;
      end
      if (legacy && !s_reg.compat) begin
        ok = 1'b0;
      end
      // A refused command must not leave a partial change behind
      if (!ok) begin
        s_next.level = s_reg.level;
        s_next.contrast = s_reg.contrast;
        s_next.comp_en = s_reg.comp_en;
        s_next.run = s_reg.run;
        s_next.eoc = s_reg.eoc;
        ev[mci_pkg::MCI_IRQ_NAK_BIT] = 1'b1;
      end
      s_next.rsp.valid = 1'b1;
      s_next.rsp.ack = ok;
      s_next.rsp.nak = ~ok;
      s_next.rsp.data = (ok && cmd_i.query) ? dat : 32'h0000_0000;
    end

    // Capture after the fetch so a new value in the same cycle keeps bit 8 set
    if (capture) begin
      s_next.meas_buf = meas_value_i;
      s_next.eoc = 1'b1;
      s_next.qerr = meas_error_i;
      ev[mci_pkg::MCI_IRQ_NEW_BIT] = 1'b1;
      ev[mci_pkg::MCI_IRQ_ERR_BIT] = meas_error_i;
    end

    // Register writes; status clears lose against events of the same cycle
    if (wb_wr && wb_sel_i[0]) begin
      unique case (adr)
        mci_pkg::MCI_OFS_CTRL: begin
          s_next.compat = wb_dat_i[mci_pkg::MCI_CTRL_COMPAT_BIT];
          s_next.cont = wb_dat_i[mci_pkg::MCI_CTRL_CONT_BIT];
        end
        mci_pkg::MCI_OFS_IRQ_STAT: s_next.irq_stat = s_reg.irq_stat & ~wb_dat_i[2:0];
        mci_pkg::MCI_OFS_IRQ_MASK: s_next.irq_mask = wb_dat_i[2:0];
        default: s_next.irq_mask = s_next.irq_mask;
      endcase
    end
    s_next.irq_stat = s_next.irq_stat | ev;
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);

    if (wb_hit && !wb_we_i) begin
      unique case (adr)
        mci_pkg::MCI_OFS_CTRL: begin
          s_next.wb_dat[mci_pkg::MCI_CTRL_COMPAT_BIT] = s_reg.compat;
          s_next.wb_dat[mci_pkg::MCI_CTRL_CONT_BIT] = s_reg.cont;
        end
        mci_pkg::MCI_OFS_STATUS: begin
          s_next.wb_dat[mci_pkg::MCI_STAT_RUN_BIT] = s_reg.run == mci_pkg::MCI_ST_RUN;
          s_next.wb_dat[mci_pkg::MCI_OP_EOC_BIT] = s_reg.eoc;
          s_next.wb_dat[mci_pkg::MCI_QUES_ERR_BIT] = s_reg.qerr;
        end
        mci_pkg::MCI_OFS_SETTINGS: begin
          s_next.wb_dat[2:0] = s_reg.level;
          s_next.wb_dat[mci_pkg::MCI_SET_COMP_BIT] = s_reg.comp_en;
          s_next.wb_dat[mci_pkg::MCI_SET_CONTR_LSB +: 4] = s_reg.contrast;
        end
        mci_pkg::MCI_OFS_MEAS: s_next.wb_dat = s_reg.meas_buf;
        mci_pkg::MCI_OFS_IRQ_STAT: s_next.wb_dat[2:0] = s_reg.irq_stat;
        mci_pkg::MCI_OFS_IRQ_MASK: s_next.wb_dat[2:0] = s_reg.irq_mask;
        default: s_next.wb_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.run <= mci_pkg::MCI_ST_IDLE;
      s_reg.compat <= mci_pkg::MCI_RST_COMPAT;
      s_reg.cont <= mci_pkg::MCI_RST_CONT;
      s_reg.level <= mci_pkg::MCI_RST_LEVEL;
      s_reg.contrast <= mci_pkg::MCI_RST_CONTR;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_dat_o = s_reg.wb_dat;
  assign wb_ack_o = s_reg.wb_ack;
  assign rsp_o = s_reg.rsp;
  assign irq_o = s_reg.irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_compat_gate: assert property (
    cmd_valid_i && legacy && !s_reg.compat |=> rsp_o.nak && !rsp_o.ack)
    else $error("legacy command accepted outside compatibility mode");
  a_addr_refuse: assert property (
    cmd_valid_i && (cmd_i.op inside {mci_pkg::MCI_OP_ADDR_GRP, mci_pkg::MCI_OP_ADDR_USR})
    |=> rsp_o.valid && rsp_o.nak)
    else $error("address setting not refused");
  a_leg_refuse: assert property (
    cmd_valid_i && (cmd_i.op inside {mci_pkg::MCI_OP_LEG_A, mci_pkg::MCI_OP_LEG_READ})
    |=> rsp_o.nak)
    else $error("legacy legacy_command_a or read not refused");
  a_dry_refuse: assert property (
    cmd_valid_i && (cmd_i.op inside {mci_pkg::MCI_OP_DRY, mci_pkg::MCI_OP_CONTACT_V})
    |=> rsp_o.nak)
    else $error("dry contact not refused");
  a_idn_data: assert property (
    cmd_valid_i && cmd_i.query && cmd_i.op == mci_pkg::MCI_OP_IDN
    && s_reg.level >= mci_pkg::MCI_LVL_START
    |=> rsp_o.ack && rsp_o.data == {mci_pkg::MCI_IDN_TAG, DEV_ID})
    else $error("identification answer wrong");
  a_buf_newest: assert property (
    capture |=> s_reg.meas_buf == $past(meas_value_i))
    else $error("buffer missed the newest value");
  a_eoc_set: assert property (
    capture |=> s_reg.eoc ##1 (s_reg.eoc || $past(cmd_valid_i)))
    else $error("operation bit 8 not set after a value");
  a_qerr_flag: assert property (
    capture |=> s_reg.qerr == $past(meas_error_i))
    else $error("questionable bit 9 does not follow the error");
  a_lvl_gate: assert property (
    cmd_valid_i && cmd_i.op == mci_pkg::MCI_OP_LIMIT
    && s_reg.level < mci_pkg::MCI_LVL_LIMIT |=> rsp_o.nak)
    else $error("limit command passed below level 3");
  a_bad_param: assert property (
    cmd_valid_i && cmd_i.op == mci_pkg::MCI_OP_CONTRAST && cmd_i.has_param
    && cmd_i.param > 16'(mci_pkg::MCI_CONTR_MAX)
    |=> rsp_o.nak && $stable(s_reg.contrast))
    else $error("contrast out of range accepted");
  a_comp_query: assert property (
    cmd_valid_i && cmd_i.op == mci_pkg::MCI_OP_COMP_EN && cmd_i.query
    && !cmd_i.has_param && s_reg.level == mci_pkg::MCI_LVL_FULL
    |=> rsp_o.data == 32'(s_reg.comp_en))
    else $error("comparator query answer wrong");
  a_ignored_cmd: assert property (
    cmd_valid_i && s_reg.compat && cmd_i.op == mci_pkg::MCI_OP_KEY_LOCK
    |=> rsp_o.ack && $stable(s_reg.level) && $stable(s_reg.comp_en))
    else $error("ignored command had an effect");
  a_rsp_every: assert property (
    cmd_valid_i |=> rsp_o.valid && (rsp_o.ack != rsp_o.nak))
    else $error("command left without a single answer");
  a_fetch_clear: assert property (
    cmd_valid_i && cmd_i.op == mci_pkg::MCI_OP_FETCH && cmd_i.query && !capture
    |=> rsp_o.ack && !s_reg.eoc && rsp_o.data == $past(s_reg.meas_buf))
    else $error("fetch did not clear bit 8 or return the buffer");
  a_access_set: assert property (
    cmd_valid_i && cmd_i.op == mci_pkg::MCI_OP_ACCESS && cmd_i.query && cmd_i.has_param
    && cmd_i.param >= 16'(mci_pkg::MCI_LVL_START) && cmd_i.param <= 16'(mci_pkg::MCI_LVL_FULL)
    |=> rsp_o.ack && rsp_o.data == 32'($past(cmd_i.param))
    && 16'(s_reg.level) == $past(cmd_i.param))
    else $error("access level not set before the answer");
  a_contr_query: assert property (
    cmd_valid_i && cmd_i.op == mci_pkg::MCI_OP_CONTRAST && cmd_i.query && !cmd_i.has_param
    && s_reg.level == mci_pkg::MCI_LVL_FULL
    |=> rsp_o.ack && rsp_o.data == 32'(s_reg.contrast))
    else $error("contrast query answer wrong");
  a_comp_set: assert property (
    cmd_valid_i && cmd_i.op == mci_pkg::MCI_OP_COMP_EN && cmd_i.has_param
    && cmd_i.param <= 16'h0001 && s_reg.level == mci_pkg::MCI_LVL_FULL
    |=> rsp_o.ack && 16'(s_reg.comp_en) == $past(cmd_i.param))
    else $error("comparator enable not applied");
  a_wb_ack_once: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held for two cycles");

  c_fetch_value: cover property (capture ##[1:20] cmd_valid_i
    && cmd_i.op == mci_pkg::MCI_OP_FETCH);
  c_set_query: cover property (cmd_valid_i && cmd_i.has_param && cmd_i.query
    && cmd_i.op == mci_pkg::MCI_OP_CONTRAST ##1 rsp_o.ack);
  c_irq_raise: cover property (!irq_o ##1 irq_o);
  c_err_value: cover property (capture && meas_error_i);
endmodule

// File: testbench/mci_host.sv
// Host controller model issuing decoded commands toward the interpreter
`timescale 1ns/1ps
module mci_host (
  // Clock
  input wire logic clk_i,
  // Command out
  output logic cmd_valid_o,
  output mci_pkg::mci_cmd_s cmd_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end
  // One command per call; the parameter is scrambled once the strobe drops
  task automatic send(input mci_pkg::mci_op_e op, input logic q, input logic hp,
                      input logic [15:0] p, input logic sf);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_o <= '{op: op, query: q, has_param: hp, short_form: sf, param: p};
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_o.param <= ~p;
  endtask
endmodule

// File: testbench/meter_command_interpreter_tb.sv
// Self-checking bench of the meter command interpreter
`timescale 1ns/1ps
module meter_command_interpreter_tb;
  typedef struct packed {
    logic ack;
    logic nak;
    logic [31:0] data;
  } mci_exp_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic cmd_valid_i;
  mci_pkg::mci_cmd_s cmd_i;
  mci_pkg::mci_rsp_s rsp_o;
  logic meas_valid_i = 1'b0;
  logic [31:0] meas_value_i = 32'h0;
  logic meas_error_i = 1'b0;
  logic irq_o;
  int fail_count = 0;
  int num_checks = 0;
  int seed = 32'hcf1b;
  mci_exp_s rq[$];
  logic [31:0] dq[$];
  logic [31:0] v0;
  logic [31:0] v1;
  int i;
  mci_pkg::mci_op_e leg[9] = '{mci_pkg::MCI_OP_LEG_A, mci_pkg::MCI_OP_LEG_READ,
    mci_pkg::MCI_OP_ADDR_GRP, mci_pkg::MCI_OP_ADDR_USR, mci_pkg::MCI_OP_CONTACT_V,
    mci_pkg::MCI_OP_RANGE_SAVE, mci_pkg::MCI_OP_DISP_TEST, mci_pkg::MCI_OP_KEY_LOCK,
    mci_pkg::MCI_OP_DRY};

  always #5 clk_i = ~clk_i;

  mci_core i_mci_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .rsp_o(rsp_o),
    .meas_valid_i(meas_valid_i), .meas_value_i(meas_value_i),
    .meas_error_i(meas_error_i), .irq_o(irq_o));
  mci_host i_mci_host (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Results are matched in arrival order against the notes of the drivers
  always @(posedge clk_i) begin
    if (rsp_o.valid === 1'b1) begin
      if (rq.size() == 0) chk({rsp_o.ack, rsp_o.nak, rsp_o.data}, 34'h0);
      else chk({rsp_o.ack, rsp_o.nak, rsp_o.data}, rq.pop_front());
    end
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (dq.size() == 0) chk({2'h0, wb_dat_o}, 34'h3FFFFFFFF);
      else chk({2'h0, wb_dat_o}, {2'h0, dq.pop_front()});
    end
  end

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    dq.push_back(e);
    wb(1'b0, a, ~e);
  endtask

  task automatic cmd(input mci_pkg::mci_op_e op, input logic q, input logic hp,
                     input logic [15:0] p, input logic ok, input logic [31:0] d);
    logic [31:0] r;
    r = $random(seed);
    rq.push_back({ok, ~ok, d});
    i_mci_host.send(op, q, hp, p, r[0]);
  endtask

  task automatic meas(input logic [31:0] v, input logic e);
    @(posedge clk_i);
    meas_valid_i <= 1'b1;
    meas_value_i <= v;
    meas_error_i <= e;
    @(posedge clk_i);
    meas_valid_i <= 1'b0;
    meas_value_i <= ~v;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h2);
    rd(8'h08, 32'h504);
    rd(8'h04, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h1C, 32'h0);
    $display("test reset done");
    cmd(mci_pkg::MCI_OP_IDN, 1'b1, 1'b0, 16'h0, 1'b1, {mci_pkg::MCI_IDN_TAG, 16'h0001});
    for (i = 0; i < 9; i++) cmd(leg[i], 1'b0, 1'b0, 16'h0, 1'b0, 32'h0);
    wb(1'b1, 8'h00, 32'h3);
    for (i = 0; i < 9; i++) cmd(leg[i], 1'b0, 1'b1, 16'h1, i >= 5 && i <= 7, 32'h0);
    rd(8'h10, 32'h1);
    wb(1'b1, 8'h10, 32'h1);
    rd(8'h10, 32'h0);
    $display("test legacy done");
    cmd(mci_pkg::MCI_OP_CONTRAST, 1'b1, 1'b1, 16'h7, 1'b1, 32'h7);
    cmd(mci_pkg::MCI_OP_CONTRAST, 1'b0, 1'b1, 16'hA, 1'b1, 32'h0);
    cmd(mci_pkg::MCI_OP_CONTRAST, 1'b1, 1'b1, 16'hB, 1'b0, 32'h0);
    cmd(mci_pkg::MCI_OP_CONTRAST, 1'b1, 1'b0, 16'h0, 1'b1, 32'hA);
    cmd(mci_pkg::MCI_OP_CONTRAST, 1'b0, 1'b1, 16'h0, 1'b1, 32'h0);
    cmd(mci_pkg::MCI_OP_COMP_EN, 1'b0, 1'b1, 16'h1, 1'b1, 32'h0);
    cmd(mci_pkg::MCI_OP_COMP_EN, 1'b1, 1'b0, 16'h0, 1'b1, 32'h1);
    cmd(mci_pkg::MCI_OP_COMP_EN, 1'b0, 1'b1, 16'h2, 1'b0, 32'h0);
    rd(8'h08, 32'h14);
    cmd(mci_pkg::MCI_OP_COMP_EN, 1'b1, 1'b1, 16'h0, 1'b1, 32'h0);
    $display("test settings done");
    cmd(mci_pkg::MCI_OP_ACCESS, 1'b0, 1'b1, 16'h0, 1'b0, 32'h0);
    cmd(mci_pkg::MCI_OP_ACCESS, 1'b0, 1'b1, 16'h5, 1'b0, 32'h0);
    for (i = 1; i <= 4; i++) begin
      cmd(mci_pkg::MCI_OP_ACCESS, 1'b1, 1'b1, 16'(i), 1'b1, 32'(i));
      cmd(mci_pkg::MCI_OP_RANGE, 1'b0, 1'b0, 16'h0, i >= 2, 32'h0);
      cmd(mci_pkg::MCI_OP_LIMIT, 1'b0, 1'b0, 16'h0, i >= 3, 32'h0);
      cmd(mci_pkg::MCI_OP_OTHER, 1'b0, 1'b0, 16'h0, i == 4, 32'h0);
      cmd(mci_pkg::MCI_OP_ABORT, 1'b0, 1'b0, 16'h0, 1'b1, 32'h0);
    end
    $display("test access done");
    wb(1'b1, 8'h10, 32'h7);
    wb(1'b1, 8'h14, 32'h7);
    meas(32'h1234_5678, 1'b1);
    rd(8'h04, 32'h0);
    cmd(mci_pkg::MCI_OP_INIT, 1'b0, 1'b0, 16'h0, 1'b1, 32'h0);
    v0 = $random(seed);
    v1 = $random(seed);
    meas(v0, 1'b0);
    rd(8'h04, 32'h101);
    rd(8'h10, 32'h2);
    chk({33'h0, irq_o}, 34'h1);
    meas(v1, 1'b1);
    rd(8'h0C, v1);
    rd(8'h04, 32'h301);
    cmd(mci_pkg::MCI_OP_FETCH, 1'b1, 1'b0, 16'h0, 1'b1, v1);
    rd(8'h04, 32'h201);
    meas(v0, 1'b0);
    rd(8'h04, 32'h101);
    wb(1'b1, 8'h00, 32'h1);
    meas(v1, 1'b1);
    rd(8'h0C, v0);
    wb(1'b1, 8'h10, 32'h7);
    rd(8'h10, 32'h0);
    chk({33'h0, irq_o}, 34'h0);
    wb(1'b1, 8'h14, 32'h0);
    cmd(mci_pkg::MCI_OP_LEG_A, 1'b0, 1'b0, 16'h0, 1'b0, 32'h0);
    rd(8'h10, 32'h1);
    chk({33'h0, irq_o}, 34'h0);
    $display("test measurement done");
    repeat (5) @(posedge clk_i);
    chk(34'(rq.size() + dq.size()), 34'h0);
    test_done();
  end
endmodule
